// file: hdl/serial_word_eeprom_access.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module serial_word_eeprom_access #(
	parameter int PROG_CYCLES_P = eeprom_pkg::PROG_CYCLES
) (
	// system
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	input wire logic link_clk,
	input wire logic sel,
	input wire logic din,
	output logic dout,
	output logic dout_oe_n,
	// supply monitor
	input wire logic low_supply
);
	import eeprom_pkg::*;

	// --------------------------------------------------------------
	// shared storage
	// --------------------------------------------------------------
	// RULE1 word-only array
	logic [DATA_W-1:0] mem [0:WORDS_MAX-1];

	logic [1:0] density_q;
	logic [ADDR_W-1:0] mask_p;
	logic [ADDR_W-1:0] mask_l;
	logic low_l;
	logic low_p;
	logic req_q;
	logic req_p;
	logic ack_q;
	logic ack_l;

	// RULE1 density mask
	always_comb begin
		unique case (density_q)
			DENS_256: mask_p = MASK_256;
			DENS_128: mask_p = MASK_128;
			default: mask_p = MASK_64;
		endcase
	end

	// --------------------------------------------------------------
	// crossings
	// --------------------------------------------------------------
	bit_sync #(.WIDTH(ADDR_W)) u_mask_sync (
		.clk(link_clk),
		.rst_n(presetn),
		.d(mask_p),
		.q(mask_l)
	);

	bit_sync #(.WIDTH(2)) u_link_sync (
		.clk(link_clk),
		.rst_n(presetn),
		.d({low_supply, ack_q}),
		.q({low_l, ack_l})
	);

	bit_sync #(.WIDTH(2)) u_prog_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({low_supply, req_q}),
		.q({low_p, req_p})
	);

	// --------------------------------------------------------------
	// link side
	// --------------------------------------------------------------
	link_state_type lstate_q;
	logic [3:0] bit_q;
	logic [12:0] hdr_q;
	logic [12:0] hdr_d;
	logic [DATA_W-1:0] word_q;
	logic [DATA_W-1:0] word_d;
	logic [2:0] op_q;
	logic [1:0] cnt_q;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] ptr_q;
	logic [1:0] widx_q;
	logic [DATA_W-1:0] pdata_q [0:PAGE_WORDS-1];
	logic dout_q;
	logic drive_q;
	logic pending;
	logic hdr_end;
	logic word_end;
	logic issue;
	logic [2:0] hdr_op;

	assign hdr_d = {hdr_q[11:0], din};
	assign word_d = {word_q[DATA_W-2:0], din};
	assign hdr_op = hdr_d[HDR_OP_LSB +: 3];
	assign pending = (req_q != ack_l);
	assign hdr_end = (lstate_q == L_HDR) && (bit_q == HDR_LAST);
	assign word_end = (lstate_q == L_DATA) && (bit_q == BIT_LAST);

	// RULE14 no issue on low supply
	always_comb begin
		issue = 1'b0;
		if (sel && !low_l) begin
			if (hdr_end && (hdr_op == OP_SETPROT || hdr_op == OP_LOCK)) begin
				issue = 1'b1;
			end else if (word_end && (op_q != OP_PAGE || widx_q == cnt_q)) begin
				issue = 1'b1;
			end
		end
	end

	// request toggle, payload stays until acknowledged
	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			req_q <= 1'b0;
		end else if (issue) begin
			req_q <= ~req_q;
		end
	end

	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			lstate_q <= L_IDLE;
			bit_q <= 4'h0;
			drive_q <= 1'b0;
			dout_q <= 1'b0;
		end else if (!sel) begin
			// RULE15 abort on deselect
			lstate_q <= L_IDLE;
			bit_q <= 4'h0;
			drive_q <= 1'b0;
		end else begin
			unique case (lstate_q)
				L_IDLE: begin
					if (pending) begin
						// RULE16 busy refuses instructions
						lstate_q <= L_STATUS;
						drive_q <= 1'b1;
						dout_q <= 1'b0;
					end else if (din && !low_l) begin
						// RULE14 start bit ignored on low supply
						lstate_q <= L_HDR;
						bit_q <= 4'h0;
					end
				end
				L_HDR: begin
					bit_q <= bit_q + 4'h1;
					if (hdr_end) begin
						bit_q <= 4'h0;
						unique case (hdr_op)
							OP_READ: begin
								lstate_q <= L_READ;
								drive_q <= 1'b1;
							end
							OP_WRITE, OP_PAGE, OP_WRALL: begin
								lstate_q <= L_DATA;
							end
							default: begin
								lstate_q <= L_STATUS;
								drive_q <= 1'b1;
								dout_q <= ~issue;
							end
						endcase
					end
				end
				L_DATA: begin
					bit_q <= bit_q + 4'h1;
					if (issue) begin
						lstate_q <= L_STATUS;
						drive_q <= 1'b1;
						dout_q <= 1'b0;
					end
				end
				L_READ: begin
					// RULE2 shift word out, msb first
					dout_q <= mem[ptr_q][BIT_LAST - bit_q];
					bit_q <= bit_q + 4'h1;
				end
				L_STATUS: begin
					// RULE13 ready/busy on data pin
					dout_q <= ~pending;
				end
			endcase
		end
	end

	// header and data capture
	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			hdr_q <= 13'h0;
			word_q <= '0;
			op_q <= 3'h0;
			cnt_q <= 2'h0;
			addr_q <= '0;
			widx_q <= 2'h0;
		end else if (sel) begin
			if (lstate_q == L_HDR) begin
				hdr_q <= hdr_d;
			end
			if (hdr_end) begin
				op_q <= hdr_op;
				cnt_q <= hdr_d[HDR_CNT_LSB +: 2];
				addr_q <= hdr_d[ADDR_W-1:0];
				widx_q <= 2'h0;
			end
			if (lstate_q == L_DATA) begin
				word_q <= word_d;
			end
			if (word_end) begin
				widx_q <= widx_q + 2'h1;
			end
		end
	end

	always_ff @(posedge link_clk) begin
		if (sel && word_end) begin
			pdata_q[widx_q] <= word_d;
		end
	end

	// RULE3 pointer steps per word
	always_ff @(posedge link_clk or negedge presetn) begin
		if (!presetn) begin
			ptr_q <= '0;
		end else if (sel && hdr_end) begin
			ptr_q <= hdr_d[ADDR_W-1:0] & mask_l;
		end else if (sel && lstate_q == L_READ && bit_q == BIT_LAST) begin
			// RULE4 wrap to 00 at the top
			ptr_q <= (ptr_q + 8'h01) & mask_l;
		end
	end

	assign dout = dout_q;
	assign dout_oe_n = ~(sel && drive_q);

	// --------------------------------------------------------------
	// programming engine
	// --------------------------------------------------------------
	prog_state_type pstate_q;
	logic [2:0] pop_q;
	logic [1:0] pcnt_q;
	logic [ADDR_W-1:0] paddr_q;
	logic [ADDR_W-1:0] idx_q;
	logic [ADDR_W-1:0] last_idx;
	logic [ADDR_W-1:0] waddr;
	logic refuse_q;
	logic refuse_d;
	logic lock_q;
	logic prot_en_q;
	logic [ADDR_W-1:0] bound_q;
	logic timer_start;
	logic timer_done;
	logic [15:0] cycles_q;
	logic [ADDR_W-1:0] chk_addr;

	function automatic logic protected_word(input logic [ADDR_W-1:0] a, input logic en,
			input logic [ADDR_W-1:0] b);
		protected_word = en && (a >= b);
	endfunction

	// RULE12 all targets must be free
	always_comb begin
		refuse_d = 1'b0;
		chk_addr = '0;
		if (pop_q == OP_SETPROT || pop_q == OP_LOCK) begin
			// RULE8 locked protect register
			refuse_d = lock_q;
		end else if (pop_q == OP_WRITE || pop_q == OP_PAGE) begin
			for (int i = 0; i < PAGE_WORDS; i++) begin
				chk_addr = (paddr_q + ADDR_W'(i)) & mask_p;
				if ((pop_q == OP_PAGE && i <= int'(pcnt_q)) || i == 0) begin
					if (protected_word(chk_addr, prot_en_q, bound_q)) begin
						refuse_d = 1'b1;
					end
				end
			end
		end
	end

	always_comb begin
		unique case (pop_q)
			OP_WRALL: last_idx = mask_p;
			OP_PAGE: last_idx = {6'h00, pcnt_q};
			default: last_idx = '0;
		endcase
	end

	assign waddr = (pop_q == OP_WRALL) ? idx_q : ((paddr_q + idx_q) & mask_p);
	assign timer_start = (pstate_q == P_CHECK);

	// RULE9 cycle length set by pclk only
	cycle_timer #(.CYCLES(PROG_CYCLES_P)) u_timer (
		.clk(pclk),
		.rst_n(presetn),
		.start(timer_start),
		.done(timer_done)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pstate_q <= P_IDLE;
			ack_q <= 1'b0;
			pop_q <= 3'h0;
			pcnt_q <= 2'h0;
			paddr_q <= '0;
			idx_q <= '0;
			refuse_q <= 1'b0;
		end else begin
			unique case (pstate_q)
				P_IDLE: begin
					if (req_p != ack_q) begin
						pop_q <= op_q;
						pcnt_q <= cnt_q;
						paddr_q <= addr_q;
						// RULE14 inhibit on low supply
						pstate_q <= low_p ? P_DONE : P_CHECK;
					end
				end
				P_CHECK: begin
					refuse_q <= refuse_d;
					idx_q <= '0;
					pstate_q <= P_WRITE;
				end
				P_WRITE: begin
					idx_q <= idx_q + 8'h01;
					if (idx_q == last_idx) begin
						pstate_q <= P_WAIT;
					end
				end
				P_WAIT: begin
					if (timer_done) begin
						pstate_q <= P_DONE;
					end
				end
				P_DONE: begin
					ack_q <= req_p;
					pstate_q <= P_IDLE;
				end
			endcase
		end
	end

	// RULE10 write replaces word, no erase step
	always_ff @(posedge pclk) begin
		if (pstate_q == P_WRITE && !refuse_q) begin
			if (pop_q == OP_WRITE || pop_q == OP_PAGE) begin
				// RULE5 RULE11 word and page program
				mem[waddr] <= pdata_q[idx_q[1:0]];
			end else if (pop_q == OP_WRALL && !protected_word(waddr, prot_en_q, bound_q)) begin
				// RULE6 RULE7 fill all free words
				mem[waddr] <= pdata_q[0];
			end
		end
	end

	// RULE7 protect register and lock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_q <= 1'b0;
			prot_en_q <= 1'b0;
			bound_q <= '0;
		end else if (pstate_q == P_WRITE && !refuse_q) begin
			if (pop_q == OP_SETPROT) begin
				prot_en_q <= 1'b1;
				bound_q <= paddr_q;
			end else if (pop_q == OP_LOCK) begin
				lock_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycles_q <= 16'h0;
		end else if (pstate_q == P_WAIT && timer_done) begin
			cycles_q <= cycles_q + 16'h1;
		end
	end

	// --------------------------------------------------------------
	// apb registers
	// --------------------------------------------------------------
	logic setup;
	logic mapped;
	logic [31:0] rd_d;

	assign setup = psel && !penable;
	assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_COUNT);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		rd_d = 32'h0;
		unique case (paddr)
			ADDR_CTRL: rd_d[1:0] = density_q;
			ADDR_STATUS: begin
				rd_d[ST_BUSY] = (pstate_q != P_IDLE);
				rd_d[ST_LOCK] = lock_q;
				rd_d[ST_PROT_EN] = prot_en_q;
				rd_d[ST_LOW] = low_p;
				rd_d[ST_BOUND_LSB +: ADDR_W] = bound_q;
			end
			ADDR_COUNT: rd_d[15:0] = cycles_q;
			default: rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (setup && !pwrite) begin
			prdata <= rd_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			density_q <= CTRL_RESET;
		end else if (psel && penable && pwrite && paddr == ADDR_CTRL) begin
			density_q <= pwdata[1:0];
		end
	end

endmodule

// file: hdl/eeprom_pkg.sv
// Overview of operation
// RULE1: The array holds only 16-bit words, 256, 128 or 64 of them by density, one word per address.
// RULE2: A read loads its address into the pointer and shifts that word out on the data pin.
// RULE3: After each word the pointer steps by one and words keep coming while select stays high.
// RULE4: Stepping past the top address wraps the pointer to address 00.
// RULE5: A page write takes up to 4 words into consecutive addresses in one programming cycle.
// RULE6: Write-all programs every word of the array with one given pattern. The code skips the words inside the protected region.
// RULE7: The protect register sets a region that write instructions cannot change.
// RULE8: Once the lock bit is programmed the protect register can never change again.
// RULE9: Programming is timed inside and finishes whether the serial clock runs or stops.
// RULE10: Every write erases its target itself, so no separate erase is needed.
// RULE11: A single-word write programs all 16 bits of one word in one cycle.
// RULE12: Word and page writes act only when every targeted address is outside the region.
// RULE13: After programming starts, select high shows busy or ready on the data pin for polling.
// RULE14: While supply is low every instruction is ignored and nothing can change.
// RULE15: Select low aborts a partial instruction, ends a read and floats the data pin.
// RULE16: No new instruction is taken while a programming cycle is running.
package eeprom_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int PAGE_WORDS = 4;
	localparam int WORDS_MAX = 256;

	// serial frame: start bit, then opcode, word count - 1, address
	localparam logic [3:0] HDR_LAST = 4'hC;
	localparam logic [3:0] BIT_LAST = 4'hF;
	localparam int HDR_OP_LSB = 10;
	localparam int HDR_CNT_LSB = 8;

	localparam logic [2:0] OP_READ = 3'h6;
	localparam logic [2:0] OP_WRITE = 3'h5;
	localparam logic [2:0] OP_PAGE = 3'h4;
	localparam logic [2:0] OP_WRALL = 3'h1;
	localparam logic [2:0] OP_SETPROT = 3'h3;
	localparam logic [2:0] OP_LOCK = 3'h2;

	localparam logic [1:0] DENS_256 = 2'h0;
	localparam logic [1:0] DENS_128 = 2'h1;
	localparam logic [7:0] MASK_256 = 8'hFF;
	localparam logic [7:0] MASK_128 = 8'h7F;
	localparam logic [7:0] MASK_64 = 8'h3F;

	// register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_COUNT = 8'h08;
	localparam int ST_BUSY = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_PROT_EN = 2;
	localparam int ST_LOW = 3;
	localparam int ST_BOUND_LSB = 8;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// programming time
	localparam int PROG_TIME_US = 5000;
	localparam int CLK_FREQ_MHZ = 20;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_FREQ_MHZ;

	typedef enum logic [2:0] {L_IDLE, L_HDR, L_DATA, L_READ, L_STATUS} link_state_type;
	typedef enum logic [2:0] {P_IDLE, P_CHECK, P_WRITE, P_WAIT, P_DONE} prog_state_type;

endpackage

// file: hdl/bit_sync.sv
`timescale 1ns/100ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// file: hdl/cycle_timer.sv
`timescale 1ns/100ps
module cycle_timer #(
	parameter int CYCLES = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic start,
	output logic done
);
	logic [31:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
		end else if (start) begin
			cnt_q <= 32'(CYCLES);
		end else if (cnt_q != 32'h0) begin
			cnt_q <= cnt_q - 32'h1;
		end
	end

	assign done = (cnt_q == 32'h1);
endmodule

// file: tb/eeprom_access_asserts.sv
`timescale 1ns/100ps
module eeprom_access_asserts
	import eeprom_pkg::*;
#(
	parameter int PROG_CYCLES_P = 400
) (
	// apb side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// serial side
	input wire logic link_clk,
	input wire logic sel,
	input wire logic dout_oe_n,
	input wire logic low_supply
);
	// ----------
	// lock tracking
	// ----------
	logic acc, mapped, st_rd, lock_seen_q;
	logic [7:0] bound_q;
	assign acc = psel && penable;
	assign mapped = paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_COUNT;
	assign st_rd = acc && !pwrite && paddr == ADDR_STATUS;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_seen_q <= 1'b0;
			bound_q <= 8'h00;
		end else if (st_rd && prdata[ST_LOCK] && !lock_seen_q) begin
			lock_seen_q <= 1'b1;
			bound_q <= prdata[ST_BOUND_LSB +: 8];
		end
	end
	a_pready_high: assert property (@(posedge pclk) disable iff (!presetn) psel |-> pready)
		else $error("pready low in transfer");
	a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		!(acc && !mapped) |-> !pslverr)
		else $error("error raised on mapped or idle bus");
	a_prdata_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed outside read setup");
	a_low_status: assert property (@(posedge pclk) disable iff (!presetn)
		low_supply [*4] ##1 (st_rd && !penable || psel && !penable && !pwrite
		&& paddr == ADDR_STATUS) |=> prdata[ST_LOW])
		else $error("low supply not reported");
	a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		st_rd && lock_seen_q |-> prdata[ST_LOCK] && prdata[ST_BOUND_LSB +: 8] == bound_q)
		else $error("locked protect state changed");
	a_oe_sel_low: assert property (@(posedge link_clk) disable iff (!presetn)
		!sel |-> dout_oe_n)
		else $error("data pin driven without select");
	a_oe_first_edge: assert property (@(posedge link_clk) disable iff (!presetn)
		$rose(sel) |-> dout_oe_n)
		else $error("data pin driven before first select edge");
	c_unmapped: cover property (@(posedge pclk) acc && pslverr);
	c_locked: cover property (@(posedge pclk) st_rd && lock_seen_q);
	c_driven: cover property (@(posedge link_clk) sel && !dout_oe_n);
endmodule

bind serial_word_eeprom_access eeprom_access_asserts #(.PROG_CYCLES_P(PROG_CYCLES_P))
	i_eeprom_access_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .link_clk, .sel, .dout_oe_n, .low_supply);

// file: tb/link_host.sv
`timescale 1ns/100ps
module link_host (
	// serial link
	output logic link_clk,
	output logic sel,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe_n
);
	// ----------
	// bit timing, clock low between frames
	// ----------
	initial begin
		link_clk = 1'b0;
		sel = 1'b0;
		din = 1'b0;
	end
	task automatic tick();
		#15 link_clk = 1'b1;
		#15 link_clk = 1'b0;
	endtask
	task automatic send(input logic [63:0] v, input int n);
		#7 sel = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			din = v[i];
			tick();
		end
	endtask
	task automatic get(output logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			#15 w[i] = dout_oe_n ? 1'bx : dout;
			link_clk = 1'b1;
			#15 link_clk = 1'b0;
		end
	endtask
	task automatic poll(output int n);
		#7 sel = 1'b1;
		for (n = 1; n < 3000; n++) begin
			#15 if (!dout_oe_n && dout === 1'b1) break;
			link_clk = 1'b1;
			#15 link_clk = 1'b0;
		end
	endtask
	// released line toggles, two edges unselected
	task automatic stop();
		#7 sel = 1'b0;
		repeat (2) begin
			din = ~din;
			tick();
		end
	endtask
endmodule

// file: tb/serial_word_eeprom_access_tb.sv
`timescale 1ns/100ps
module serial_word_eeprom_access_tb;
	import eeprom_pkg::*;
	localparam int PROG = 400;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
	logic link_clk, sel, din, dout, dout_oe_n, low_supply;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	int err_count, checked, n;
	serial_word_eeprom_access #(.PROG_CYCLES_P(PROG)) i_serial_word_eeprom_access (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.link_clk, .sel, .din, .dout, .dout_oe_n, .low_supply);
	link_host i_link_host (.link_clk, .sel, .din, .dout, .dout_oe_n);
	// ----------
	// shared tasks
	// ----------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic prog(input logic [2:0] op, input logic [7:0] a, input logic [63:0] d, int nw);
		i_link_host.send({1'b1, op, 2'(nw - 1), a}, 14);
		i_link_host.send(d, 16 * nw);
		i_link_host.poll(n);
		chk("busy then ready", 1, n > 1 && n < 3000);
		i_link_host.stop();
	endtask
	task automatic rd(input logic [7:0] a, input logic [63:0] e, input int nw);
		logic [15:0] w;
		i_link_host.send({1'b1, OP_READ, 2'h0, a}, 14);
		i_link_host.tick();
		for (int i = 0; i < nw; i++) begin
			i_link_host.get(w);
			chk("read word", e[63 - 16 * i -: 16], w);
		end
		i_link_host.stop();
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ----------
	// scenarios
	// ----------
	task automatic t_regs();
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, r);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status flags", 32'h0, r & 32'h0000000F);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped error", 1, perr);
		chk("unmapped data", 32'h0, r);
		i_link_host.send({1'b1, 3'h7, 10'h000}, 14);
		i_link_host.tick();
		chk("unknown op answer", 1, !dout_oe_n && dout === 1'b1);
		i_link_host.stop();
		$display("test regs done");
	endtask
	task automatic t_word();
		prog(OP_WRALL, 8'h00, 64'h1234, 1);
		i_link_host.send({1'b1, OP_WRITE, 2'h0, 8'h3F, 16'h5AC3}, 30);
		i_link_host.stop();
		i_link_host.send({1'b1, OP_WRITE, 2'h0, 8'h20, 16'hDEAD}, 30);
		i_link_host.stop();
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("busy flag", 1, r[ST_BUSY]);
		repeat (3 * PROG) @(posedge pclk);
		i_link_host.poll(n);
		chk("ready after clock stop", 1, n < 10);
		i_link_host.stop();
		rd(8'h3F, 64'h5AC3_1234_0000_0000, 2);
		rd(8'h20, 64'h1234_0000_0000_0000, 1);
		$display("test word done");
	endtask
	task automatic t_page();
		prog(OP_PAGE, 8'hFE, 64'h1111_2222_3333_4444, 4);
		rd(8'hFE, 64'h1111_2222_3333_4444, 4);
		apb(1'b1, ADDR_CTRL, 32'h1);
		rd(8'h7F, 64'h1234_3333_0000_0000, 2);
		apb(1'b1, ADDR_CTRL, 32'h2);
		rd(8'h3F, 64'h5AC3_3333_0000_0000, 2);
		apb(1'b1, ADDR_CTRL, 32'h0);
		$display("test page done");
	endtask
	task automatic t_prot();
		prog(OP_SETPROT, 8'hF0, 64'h0, 0);
		prog(OP_PAGE, 8'hEE, 64'hAAAA_BBBB_CCCC_DDDD, 4);
		prog(OP_WRITE, 8'hF8, 64'hBEEF, 1);
		prog(OP_WRITE, 8'hEF, 64'h0F0F, 1);
		rd(8'hEE, 64'h1234_0F0F_1234_1234, 4);
		rd(8'hF8, 64'h1234_0000_0000_0000, 1);
		prog(OP_LOCK, 8'h00, 64'h0, 0);
		prog(OP_SETPROT, 8'h10, 64'h0, 0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("locked bound", 32'hF006, r & 32'h0000FF0F);
		apb(1'b0, ADDR_COUNT, 32'h0);
		chk("cycle count", 32'h9, r);
		$display("test protect done");
	endtask
	task automatic t_low();
		@(posedge pclk);
		low_supply <= 1'b1;
		apb(1'b0, ADDR_STATUS, 32'h0);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("low supply flag", 1, r[ST_LOW]);
		i_link_host.send({4'h0, 1'b1, OP_WRITE, 2'h0, 8'h3F, 16'h0F0F}, 34);
		chk("no busy when low", 1, dout_oe_n);
		i_link_host.stop();
		@(posedge pclk);
		low_supply <= 1'b0;
		repeat (6) @(posedge pclk);
		i_link_host.stop();
		i_link_host.send({1'b1, OP_READ}, 4);
		i_link_host.stop();
		i_link_host.send(10'h000, 10);
		i_link_host.tick();
		chk("float after abort", 1, dout_oe_n);
		i_link_host.stop();
		rd(8'h3F, 64'h5AC3_0000_0000_0000, 1);
		$display("test low supply done");
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, low_supply, perr} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_count = 0;
		checked = 0;
		i_link_host.stop();
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		i_link_host.stop();
		t_regs();
		t_word();
		t_page();
		t_prot();
		t_low();
		summarize();
	end
	initial begin
		#1000000;
		err_count++;
		$display("watchdog expired");
		summarize();
	end
endmodule
